// file: hdl/swpm_top.v
// Sleep and wake power manager: power-up, clocks, sleep, wake timer, watchdog, RAM banks.
// Assumes one 200 MHz clock, synchronous reset, an APB master, and asynchronous pin inputs.
// Operation
// - After hardware reset release and power-on done, bring up regulators then clocks; radio off.
// - Processor clock divider programmable from low rates up to full reference.
// - Reference from default crystal or alternative oscillator with PLL.
// - Per-function clock gating leaves unused logic without clock.
// - Light sleep keeps reference oscillator running; deep sleep stops it.
// - Sleep keeps configuration and powers only RAM selected for retention.
// - Wake runs the regulator then clock recovery before the processor resumes.
// - Transition on any of four keypad wake inputs wakes from either sleep.
// - Asserted internal interrupt can wake the device from sleep.
// - 32-bit wake timer; expiry wakes the device.
// - Deep sleep timer clock selectable: slow internal or 32.768 kHz crystal.
// - Light sleep timer counts from the reference clock.
// - Software-enabled watchdog resets the system when not serviced.
// - Software can request a system reset.
// - RAM split into four banks of 2048, 6144, 8192, 16384 words.
// - Every RAM access takes at least two clock cycles.
// - RAM stalls the requester when a read follows a write.
// - Only the accessed RAM bank receives a clock.
// - In sleep, unselected banks switch off, others go to retention.
// - In reset and sleep, general pins unpowered; keypad pins stay powered.
// - In sleep, four keypad pins hold output state, four wake inputs.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "swpm_consts.vh"

module swpm_top #(
    parameter integer WDOG_TIMEOUT_NS = `SWPM_WDOG_TIMEOUT_NS
) (
    input  wire        CLOCK,
    input  wire        RST,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    input  wire        HW_RESET_IN_N,
    input  wire        POR_DONE,
    input  wire [3:0]  KEYPAD_WAKE_PINS,
    input  wire        IRQ_IN,
    input  wire        SLOW_OSC_IN,
    input  wire        XTAL32_IN,
    input  wire        RAM_REQ,
    input  wire        RAM_WE,
    input  wire [14:0] RAM_ADDR,
    output reg         RAM_ACK,
    output reg         RAM_STALL,
    output reg  [3:0]  RAM_BANK_CLK_EN,
    output reg  [3:0]  RAM_PWR_EN,
    output reg  [3:0]  RAM_RETAIN,
    output reg         REG_EN,
    output reg         OSC_EN,
    output reg         PLL_EN,
    output reg         REF_ALT_SEL,
    output reg         CPU_RUN,
    output reg         CPU_CLK_EN,
    output reg  [7:0]  FUNC_CLK_EN,
    output reg         RADIO_PWR,
    output reg         GPIO_PWR,
    output reg  [3:0]  KEY_OUT,
    output reg         SLEEPING,
    output reg         SYS_RST_OUT
);

    localparam integer REG_CYC  = (`SWPM_REG_SETTLE_NS + `SWPM_CLK_PERIOD_NS - 1) / `SWPM_CLK_PERIOD_NS;
    localparam integer OSC_CYC  = (`SWPM_OSC_SETTLE_NS + `SWPM_CLK_PERIOD_NS - 1) / `SWPM_CLK_PERIOD_NS;
    localparam integer PLL_CYC  = (`SWPM_PLL_LOCK_NS + `SWPM_CLK_PERIOD_NS - 1) / `SWPM_CLK_PERIOD_NS;
    localparam integer WDOG_CYC = WDOG_TIMEOUT_NS / `SWPM_CLK_PERIOD_NS;

    localparam [2:0] ST_OFF   = 3'd0;
    localparam [2:0] ST_REG   = 3'd1;
    localparam [2:0] ST_CLK   = 3'd2;
    localparam [2:0] ST_RUN   = 3'd3;
    localparam [2:0] ST_ENTER = 3'd4;
    localparam [2:0] ST_SLEEP = 3'd5;

    localparam [1:0] RS_IDLE  = 2'd0;
    localparam [1:0] RS_STALL = 2'd1;
    localparam [1:0] RS_A1    = 2'd2;
    localparam [1:0] RS_A2    = 2'd3;

    // Two-stage synchronisers; a third stage feeds edge detection only
    reg  [7:0]  sync1_q;
    reg  [7:0]  sync2_q;
    reg  [7:0]  sync3_q;
    wire [7:0]  async_in = {XTAL32_IN, SLOW_OSC_IN, IRQ_IN, POR_DONE, KEYPAD_WAKE_PINS};
    wire [3:0]  key_s    = sync2_q[3:0];
    wire        por_s    = sync2_q[4];
    wire        irq_s    = sync2_q[5];
    wire        hwrst_n_s;
    reg         hw1_q;
    reg         hw2_q;
    assign hwrst_n_s = hw2_q;

    // Configuration
    reg  [5:0]  ctrl_q;
    reg  [7:0]  clkdiv_q;
    reg  [7:0]  gate_q;
    reg  [3:0]  retain_q;
    reg  [5:0]  wake_en_q;
    reg  [31:0] cmp_q;
    reg  [5:0]  wake_src_q;
    reg  [3:0]  key_out_q;
    reg         sleep_go_q;

    reg  [2:0]  st_q;
    reg  [2:0]  st_d;
    reg  [15:0] seq_cnt_q;
    reg  [15:0] seq_cnt_d;
    reg  [31:0] tmr_q;
    reg  [31:0] wdog_q;
    reg  [7:0]  div_cnt_q;
    reg         sys_rst_q;
    reg  [1:0]  rs_q;
    reg  [1:0]  rs_d;
    reg         last_we_q;
    reg  [3:0]  bank_q;

    wire        apb_wr   = PSEL & PENABLE & PREADY & PWRITE;
    wire        apb_setup = PSEL & ~PENABLE;
    wire        rst_all  = RST | sys_rst_q;
    wire        deep     = ctrl_q[`SWPM_CTRL_DEEP];
    wire        slow_sel = ctrl_q[`SWPM_CTRL_XTAL32] ? sync2_q[7] : sync2_q[6];
    wire        slow_prv = ctrl_q[`SWPM_CTRL_XTAL32] ? sync3_q[7] : sync3_q[6];
    wire        slow_tick = slow_sel & ~slow_prv;
    wire [3:0]  key_evt  = (key_s ^ sync3_q[3:0]) & wake_en_q[3:0];
    wire        irq_evt  = irq_s & wake_en_q[`SWPM_WS_IRQ];
    wire        tmr_evt  = (tmr_q == cmp_q) & wake_en_q[`SWPM_WS_TIMER];
    wire        in_sleep = (st_q == ST_SLEEP);
    wire [5:0]  wake_evt = in_sleep ? {tmr_evt, irq_evt, key_evt} : 6'h00;
    wire        wdog_exp = ctrl_q[`SWPM_CTRL_WDOG] & (st_q == ST_RUN) & (wdog_q >= WDOG_CYC);
    wire        swrst_req = apb_wr & (PADDR == `SWPM_A_SW_RST) & (PWDATA == `SWPM_RST_KEY);
    wire        wdog_svc = apb_wr & (PADDR == `SWPM_A_WDOG_SVC) & (PWDATA == `SWPM_WDOG_KEY);

    always @(posedge CLOCK) begin
        if (RST) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
            sync3_q <= 8'h00;
            hw1_q   <= 1'b0;
            hw2_q   <= 1'b0;
        end else begin
            sync1_q <= async_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            hw1_q   <= HW_RESET_IN_N;
            hw2_q   <= hw1_q;
        end
    end

    // Power sequencer
    always @* begin
        st_d      = st_q;
        seq_cnt_d = seq_cnt_q;
        if (seq_cnt_q != 16'h0000) begin
            seq_cnt_d = seq_cnt_q - 16'h0001;
        end
        case (st_q)
            ST_OFF: begin
                if (hwrst_n_s & por_s) begin
                    st_d      = ST_REG;
                    seq_cnt_d = REG_CYC[15:0];
                end
            end
            ST_REG: begin
                if (seq_cnt_q == 16'h0000) begin
                    st_d = ST_CLK;
                    // Alternative reference needs the PLL to lock as well
                    seq_cnt_d = ctrl_q[`SWPM_CTRL_ALT_REF] ? PLL_CYC[15:0] : OSC_CYC[15:0];
                end
            end
            ST_CLK: begin
                if (seq_cnt_q == 16'h0000) begin
                    st_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (sleep_go_q) begin
                    st_d = ST_ENTER;
                end
            end
            ST_ENTER: begin
                st_d = ST_SLEEP;
            end
            ST_SLEEP: begin
                if (wake_evt != 6'h00) begin
                    st_d      = ST_REG;
                    seq_cnt_d = REG_CYC[15:0];
                end
            end
            default: begin
                st_d = ST_OFF;
            end
        endcase
        if (!hwrst_n_s) begin
            st_d      = ST_OFF;
            seq_cnt_d = 16'h0000;
        end
    end

    // Outputs registered from next state so they follow state with no glue
    always @(posedge CLOCK) begin
        if (rst_all) begin
            st_q        <= ST_OFF;
            seq_cnt_q   <= 16'h0000;
            REG_EN      <= 1'b0;
            OSC_EN      <= 1'b0;
            PLL_EN      <= 1'b0;
            REF_ALT_SEL <= 1'b0;
            CPU_RUN     <= 1'b0;
            RADIO_PWR   <= 1'b0;
            GPIO_PWR    <= 1'b0;
            FUNC_CLK_EN <= 8'h00;
            SLEEPING    <= 1'b0;
            RAM_PWR_EN  <= 4'h0;
            RAM_RETAIN  <= 4'h0;
        end else begin
            st_q        <= st_d;
            seq_cnt_q   <= seq_cnt_d;
            REG_EN      <= (st_d != ST_OFF) & (st_d != ST_SLEEP);
            OSC_EN      <= (st_d == ST_CLK) | (st_d == ST_RUN) | (st_d == ST_ENTER)
                           | ((st_d == ST_SLEEP) & ~deep);
            PLL_EN      <= ctrl_q[`SWPM_CTRL_ALT_REF] & ((st_d == ST_CLK) | (st_d == ST_RUN));
            REF_ALT_SEL <= ctrl_q[`SWPM_CTRL_ALT_REF];
            CPU_RUN     <= (st_d == ST_RUN);
            RADIO_PWR   <= (st_d == ST_RUN) & ctrl_q[`SWPM_CTRL_RADIO];
            GPIO_PWR    <= (st_d == ST_RUN) | (st_d == ST_ENTER);
            FUNC_CLK_EN <= (st_d == ST_RUN) ? gate_q : 8'h00;
            SLEEPING    <= (st_d == ST_SLEEP);
            // Banks not retained are cut in sleep and must be reloaded by boot code
            RAM_PWR_EN  <= (st_d == ST_SLEEP) ? retain_q : 4'hF;
            RAM_RETAIN  <= (st_d == ST_SLEEP) ? retain_q : 4'h0;
        end
    end

    // Processor clock enable: full rate at divide 0
    always @(posedge CLOCK) begin
        if (rst_all) begin
            div_cnt_q  <= 8'h00;
            CPU_CLK_EN <= 1'b0;
        end else if (st_q != ST_RUN) begin
            div_cnt_q  <= 8'h00;
            CPU_CLK_EN <= 1'b0;
        end else if (div_cnt_q >= clkdiv_q) begin
            div_cnt_q  <= 8'h00;
            CPU_CLK_EN <= 1'b1;
        end else begin
            div_cnt_q  <= div_cnt_q + 8'h01;
            CPU_CLK_EN <= 1'b0;
        end
    end

    // Wake timer; restarts on every sleep entry
    always @(posedge CLOCK) begin
        if (rst_all) begin
            tmr_q <= 32'h0000_0000;
        end else if (st_q == ST_ENTER) begin
            tmr_q <= 32'h0000_0000;
        end else if (in_sleep & (tmr_q != cmp_q)) begin
            if (deep) begin
                if (slow_tick) begin
                    tmr_q <= tmr_q + 32'h0000_0001;
                end
            end else begin
                tmr_q <= tmr_q + 32'h0000_0001;
            end
        end
    end

    // Watchdog and software reset; the reset pulse clears everything but itself and the input synchronisers
    always @(posedge CLOCK) begin
        if (RST) begin
            sys_rst_q   <= 1'b0;
            SYS_RST_OUT <= 1'b0;
        end else begin
            sys_rst_q   <= ~sys_rst_q & (wdog_exp | swrst_req);
            SYS_RST_OUT <= ~sys_rst_q & (wdog_exp | swrst_req);
        end
    end

    always @(posedge CLOCK) begin
        if (rst_all) begin
            wdog_q <= 32'h0000_0000;
        end else if (wdog_svc | ~ctrl_q[`SWPM_CTRL_WDOG] | (st_q != ST_RUN)) begin
            wdog_q <= 32'h0000_0000;
        end else begin
            wdog_q <= wdog_q + 32'h0000_0001;
        end
    end

    // Register writes; configuration survives sleep untouched
    always @(posedge CLOCK) begin
        if (rst_all) begin
            ctrl_q     <= `SWPM_CTRL_RST;
            clkdiv_q   <= `SWPM_CLKDIV_RST;
            gate_q     <= `SWPM_GATE_RST;
            retain_q   <= `SWPM_RETAIN_RST;
            wake_en_q  <= `SWPM_WAKE_EN_RST;
            cmp_q      <= `SWPM_CMP_RST;
            key_out_q  <= `SWPM_KEY_OUT_RST;
            sleep_go_q <= 1'b0;
            wake_src_q <= 6'h00;
        end else begin
            sleep_go_q <= apb_wr & (PADDR == `SWPM_A_CTRL) & PWDATA[`SWPM_CTRL_SLEEP];
            if (apb_wr) begin
                if (PADDR == `SWPM_A_CTRL) begin
                    ctrl_q <= PWDATA[5:0];
                end else if (PADDR == `SWPM_A_CLKDIV) begin
                    clkdiv_q <= PWDATA[7:0];
                end else if (PADDR == `SWPM_A_GATE) begin
                    gate_q <= PWDATA[7:0];
                end else if (PADDR == `SWPM_A_RETAIN) begin
                    retain_q <= PWDATA[3:0];
                end else if (PADDR == `SWPM_A_WAKE_EN) begin
                    wake_en_q <= PWDATA[5:0];
                end else if (PADDR == `SWPM_A_TMR_CMP) begin
                    cmp_q <= PWDATA;
                end else if (PADDR == `SWPM_A_KEY_OUT) begin
                    key_out_q <= PWDATA[3:0];
                end
            end
            // A new event in the clearing cycle wins over the clear
            if (apb_wr & (PADDR == `SWPM_A_WAKE_SRC)) begin
                wake_src_q <= (wake_src_q & ~PWDATA[5:0]) | wake_evt;
            end else begin
                wake_src_q <= wake_src_q | wake_evt;
            end
        end
    end

    // Keypad outputs hold their value through sleep
    always @(posedge CLOCK) begin
        if (rst_all) begin
            KEY_OUT <= `SWPM_KEY_OUT_RST;
        end else if (st_q != ST_SLEEP) begin
            KEY_OUT <= key_out_q;
        end
    end

    // APB: read data loaded in setup, one access cycle, no wait states
    always @(posedge CLOCK) begin
        if (rst_all) begin
            PRDATA  <= 32'h0000_0000;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= apb_setup;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            if (apb_setup) begin
                if (PADDR == `SWPM_A_CTRL) begin
                    PRDATA <= {26'h000_0000, ctrl_q};
                end else if (PADDR == `SWPM_A_CLKDIV) begin
                    PRDATA <= {24'h00_0000, clkdiv_q};
                end else if (PADDR == `SWPM_A_GATE) begin
                    PRDATA <= {24'h00_0000, gate_q};
                end else if (PADDR == `SWPM_A_RETAIN) begin
                    PRDATA <= {28'h000_0000, retain_q};
                end else if (PADDR == `SWPM_A_WAKE_EN) begin
                    PRDATA <= {26'h000_0000, wake_en_q};
                end else if (PADDR == `SWPM_A_TMR_CMP) begin
                    PRDATA <= cmp_q;
                end else if (PADDR == `SWPM_A_TMR_CNT) begin
                    PRDATA <= tmr_q;
                end else if (PADDR == `SWPM_A_WAKE_SRC) begin
                    PRDATA <= {26'h000_0000, wake_src_q};
                end else if (PADDR == `SWPM_A_STATUS) begin
                    PRDATA <= {28'h000_0000, key_s};
                    PRDATA[6:4] <= st_q;
                end else if (PADDR == `SWPM_A_KEY_OUT) begin
                    PRDATA <= {28'h000_0000, key_out_q};
                end else if ((PADDR != `SWPM_A_WDOG_SVC) && (PADDR != `SWPM_A_SW_RST)) begin
                    PSLVERR <= 1'b1;
                end
            end
        end
    end

    // RAM bank access sequencer
    function [3:0] bank_of;
        input [14:0] addr;
        begin
            if (addr < `SWPM_BANK_B_BASE) begin
                bank_of = 4'h1;
            end else if (addr < `SWPM_BANK_C_BASE) begin
                bank_of = 4'h2;
            end else if (addr < `SWPM_BANK_D_BASE) begin
                bank_of = 4'h4;
            end else begin
                bank_of = 4'h8;
            end
        end
    endfunction

    always @* begin
        rs_d = rs_q;
        case (rs_q)
            RS_IDLE: begin
                if (RAM_REQ & (st_q == ST_RUN)) begin
                    rs_d = (~RAM_WE & last_we_q) ? RS_STALL : RS_A1;
                end
            end
            RS_STALL: begin
                rs_d = RS_A1;
            end
            RS_A1: begin
                rs_d = RS_A2;
            end
            default: begin
                rs_d = RS_IDLE;
            end
        endcase
    end

    always @(posedge CLOCK) begin
        if (rst_all) begin
            rs_q            <= RS_IDLE;
            last_we_q       <= 1'b0;
            bank_q          <= 4'h0;
            RAM_ACK         <= 1'b0;
            RAM_STALL       <= 1'b0;
            RAM_BANK_CLK_EN <= 4'h0;
        end else begin
            rs_q      <= rs_d;
            RAM_ACK   <= (rs_d == RS_A2);
            RAM_STALL <= (rs_d == RS_STALL);
            if ((rs_q == RS_IDLE) && (rs_d != RS_IDLE)) begin
                bank_q <= bank_of(RAM_ADDR);
            end
            if (rs_q == RS_A2) begin
                last_we_q <= RAM_WE;
            end
            // Only the addressed bank is clocked, and only for the access
            if ((rs_d == RS_A1) || (rs_d == RS_A2)) begin
                RAM_BANK_CLK_EN <= (rs_q == RS_IDLE) ? bank_of(RAM_ADDR) : bank_q;
            end else begin
                RAM_BANK_CLK_EN <= 4'h0;
            end
        end
    end

endmodule
`default_nettype wire

// file: pkg/swpm_consts.vh
// Constants for the sleep and wake power manager: register map, fields, timing.
// Assumes a 200 MHz system clock and a 32-bit APB register bus.
`ifndef SWPM_CONSTS_VH
`define SWPM_CONSTS_VH

`define SWPM_CLK_PERIOD_NS   5
`define SWPM_REG_SETTLE_NS   1000
`define SWPM_OSC_SETTLE_NS   2000
`define SWPM_PLL_LOCK_NS     4000
`define SWPM_WDOG_TIMEOUT_NS 1000000

`define SWPM_A_CTRL     12'h000
`define SWPM_A_CLKDIV   12'h004
`define SWPM_A_GATE     12'h008
`define SWPM_A_RETAIN   12'h00C
`define SWPM_A_WAKE_EN  12'h010
`define SWPM_A_TMR_CMP  12'h014
`define SWPM_A_TMR_CNT  12'h018
`define SWPM_A_WAKE_SRC 12'h01C
`define SWPM_A_WDOG_SVC 12'h020
`define SWPM_A_SW_RST   12'h024
`define SWPM_A_STATUS   12'h028
`define SWPM_A_KEY_OUT  12'h02C

`define SWPM_CTRL_SLEEP   0
`define SWPM_CTRL_DEEP    1
`define SWPM_CTRL_WDOG    2
`define SWPM_CTRL_RADIO   3
`define SWPM_CTRL_ALT_REF 4
`define SWPM_CTRL_XTAL32  5

`define SWPM_WS_TIMER 5
`define SWPM_WS_IRQ   4

`define SWPM_WDOG_KEY  32'hA5A5_5A5A
`define SWPM_RST_KEY   32'hDEAD_0001

`define SWPM_BANK_B_BASE 15'h0800
`define SWPM_BANK_C_BASE 15'h2000
`define SWPM_BANK_D_BASE 15'h4000

`define SWPM_CTRL_RST    6'h00
`define SWPM_CLKDIV_RST  8'h00
`define SWPM_GATE_RST    8'hFF
`define SWPM_RETAIN_RST  4'hF
`define SWPM_WAKE_EN_RST 6'h3F
`define SWPM_CMP_RST     32'hFFFF_FFFF
`define SWPM_KEY_OUT_RST 4'hF

`endif

// file: test/swpm_asserts.sv
// Port checker for the sleep and wake power manager.
// Assumes it is bound onto swpm_top; one clock, synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module swpm_asserts (
    input wire logic        CLOCK,
    input wire logic        RST,
    input wire logic [14:0] RAM_ADDR,
    input wire logic        RAM_ACK,
    input wire logic        RAM_STALL,
    input wire logic [3:0]  RAM_BANK_CLK_EN,
    input wire logic [3:0]  RAM_PWR_EN,
    input wire logic [3:0]  RAM_RETAIN,
    input wire logic        REG_EN,
    input wire logic        CPU_RUN,
    input wire logic        CPU_CLK_EN,
    input wire logic [7:0]  FUNC_CLK_EN,
    input wire logic        RADIO_PWR,
    input wire logic        GPIO_PWR,
    input wire logic        SLEEPING
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    // Address held by requester until the ack, so decode is stable
    function automatic logic [3:0] bank(input logic [14:0] a);
        bank = a < 15'h0800 ? 4'h1 : a < 15'h2000 ? 4'h2 : a < 15'h4000 ? 4'h4 : 4'h8;
    endfunction
    a_bank_match: assert property (RAM_BANK_CLK_EN != 4'h0 |-> RAM_BANK_CLK_EN == bank(RAM_ADDR))
        else $error("bank clock not on the addressed bank");
    a_ack_two_cyc: assert property (RAM_ACK |-> RAM_BANK_CLK_EN != 4'h0 && $past(RAM_BANK_CLK_EN) != 4'h0)
        else $error("access acked after less than two cycles");
    a_ack_pulse: assert property (RAM_ACK |=> !RAM_ACK)
        else $error("ack longer than one cycle");
    a_stall_wait: assert property (RAM_STALL |-> !RAM_ACK ##2 RAM_ACK)
        else $error("stalled read not acked two cycles later");
    a_sleep_ram: assert property (SLEEPING |-> RAM_PWR_EN == RAM_RETAIN)
        else $error("bank power differs from retention in sleep");
    a_sleep_pins: assert property (SLEEPING |-> !GPIO_PWR && !CPU_RUN)
        else $error("pins or processor powered in sleep");
    a_sleep_clks: assert property (SLEEPING |-> FUNC_CLK_EN == 8'h00 && !CPU_CLK_EN)
        else $error("clocks running in sleep");
    a_run_order: assert property ($rose(CPU_RUN) |-> REG_EN && $past(REG_EN, 300))
        else $error("processor resumed before regulators settled");
    a_boot_radio: assert property ($rose(CPU_RUN) |-> !RADIO_PWR)
        else $error("radio powered at start-up");
endmodule
bind swpm_top swpm_asserts u_chk (.CLOCK, .RST, .RAM_ADDR, .RAM_ACK, .RAM_STALL, .RAM_BANK_CLK_EN, .RAM_PWR_EN,
    .RAM_RETAIN, .REG_EN, .CPU_RUN, .CPU_CLK_EN, .FUNC_CLK_EN, .RADIO_PWR, .GPIO_PWR, .SLEEPING);
`default_nettype wire

// file: test/swpm_partner.sv
// Wake sources outside the manager: switches, interrupt line, slow oscillators.
// Assumes the bench sets switch and interrupt levels.
`timescale 1ns/10ps
`default_nettype none
module swpm_partner (
    input  wire logic       clk,
    input  wire logic [3:0] key_cmd,
    input  wire logic       irq_cmd,
    output logic [3:0]      keys,
    output logic            irq,
    output wire logic       slow_osc,
    output wire logic       xtal32
);
    logic [7:0] cnt = 8'h00;
    initial begin
        keys = 4'h0;
        irq = 1'b0;
    end
    // Oscillators run free; far faster than real ones to keep sleeps short
    assign slow_osc = cnt[5];
    assign xtal32 = cnt[3];
    always @(posedge clk) begin
        cnt <= cnt + 8'h01;
        keys <= key_cmd;
        irq <= irq_cmd;
    end
endmodule
`default_nettype wire

// file: test/test_swpm_top.sv
// Self-checking bench for the power manager: registers, RAM, sleep and wake, resets.
// Assumes swpm_top with its checker bound in, and the wake-source model.
`timescale 1ns/10ps
`default_nettype none
`include "swpm_consts.vh"
module test_swpm_top;
    logic CLOCK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, PREADY, PSLVERR;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0000_0000, PRDATA, rd, g;
    logic HW_RESET_IN_N = 1'b0, POR_DONE = 1'b0, IRQ_IN, SLOW_OSC_IN, XTAL32_IN, irq_cmd = 1'b0;
    logic [3:0] KEYPAD_WAKE_PINS, key_cmd = 4'h0, ret, ko;
    logic RAM_REQ = 1'b0, RAM_WE = 1'b0, RAM_ACK, RAM_STALL, err, st;
    logic [14:0] RAM_ADDR = 15'h0000, a;
    logic [3:0] RAM_BANK_CLK_EN, RAM_PWR_EN, RAM_RETAIN, KEY_OUT;
    logic REG_EN, OSC_EN, PLL_EN, REF_ALT_SEL, CPU_RUN, CPU_CLK_EN, RADIO_PWR, GPIO_PWR, SLEEPING, SYS_RST_OUT;
    logic [7:0] FUNC_CLK_EN;
    logic [5:0] ctls [5] = '{6'h01, 6'h13, 6'h01, 6'h23, 6'h03};
    logic [31:0] cmps [5] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_0028, 32'h0000_0003, 32'h0000_0004};
    int fail_count = 0, n_tests = 0, seed = 45, n, i, k, lat, lw;
    always #2.5 CLOCK = ~CLOCK;
    swpm_top #(.WDOG_TIMEOUT_NS(500)) DUT (.CLOCK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
        .PREADY, .PSLVERR, .HW_RESET_IN_N, .POR_DONE, .KEYPAD_WAKE_PINS, .IRQ_IN, .SLOW_OSC_IN, .XTAL32_IN,
        .RAM_REQ, .RAM_WE, .RAM_ADDR, .RAM_ACK, .RAM_STALL, .RAM_BANK_CLK_EN, .RAM_PWR_EN, .RAM_RETAIN, .REG_EN,
        .OSC_EN, .PLL_EN, .REF_ALT_SEL, .CPU_RUN, .CPU_CLK_EN, .FUNC_CLK_EN, .RADIO_PWR, .GPIO_PWR, .KEY_OUT,
        .SLEEPING, .SYS_RST_OUT);
    swpm_partner u_far (.clk(CLOCK), .key_cmd(key_cmd), .irq_cmd(irq_cmd), .keys(KEYPAD_WAKE_PINS),
        .irq(IRQ_IN), .slow_osc(SLOW_OSC_IN), .xtal32(XTAL32_IN));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Entered just after an edge; the trailing edge keeps strobes from two writes in one step
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= ad;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do @(posedge CLOCK); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLOCK);
    endtask
    // Last clear keeps the request up so a read can follow a write at once
    task ram(input logic w, input logic [14:0] ad, input logic last);
        RAM_REQ <= 1'b1;
        RAM_WE <= w;
        RAM_ADDR <= ad;
        st = 1'b0;
        for (lat = 0; lat < 20 && !(lat > 0 && RAM_ACK === 1'b1); lat++) begin
            @(posedge CLOCK);
            if (RAM_STALL === 1'b1) st = 1'b1;
        end
        if (last) RAM_REQ <= 1'b0;
    endtask
    initial begin
        repeat (40000) @(posedge CLOCK);
        fail_count++;
        $display("[FAIL] %0t ns: run did not finish", $time);
        print_verdict;
    end
    initial begin
        repeat (12) @(posedge CLOCK);
        RST <= 1'b0;
        HW_RESET_IN_N <= 1'b1;
        POR_DONE <= 1'b1;
        for (n = 0; n < 3000 && CPU_RUN !== 1'b1; n++) @(posedge CLOCK);
        check(CPU_RUN, 1);
        check(RADIO_PWR, 0);
        apb(0, 12'h0FC, 0);
        check(err, 1);
        apb(0, `SWPM_A_RETAIN, 0);
        check(rd, `SWPM_RETAIN_RST);
        g = $random(seed) & 7;
        apb(1, `SWPM_A_CLKDIV, g);
        for (n = 0; n < 50 && CPU_CLK_EN !== 1'b1; n++) @(posedge CLOCK);
        @(posedge CLOCK);
        for (n = 1; n < 50 && CPU_CLK_EN !== 1'b1; n++) @(posedge CLOCK);
        check(n, g + 1);
        g = $random(seed);
        apb(1, `SWPM_A_GATE, g);
        @(posedge CLOCK);
        check(FUNC_CLK_EN, g[7:0]);
        $display("start-up, divider and gating done");
        for (i = 0; i < 4; i++) begin
            a = $random(seed) & 15'h07FF;
            a = a + (i == 0 ? 15'h0000 : i == 1 ? 15'h0800 : i == 2 ? 15'h2000 : 15'h4000);
            ram(1, a, 1);
            lw = lat;
            check(st, 0);
            check(lw >= 3, 1);
            @(posedge CLOCK);
            ram(1, a, 0);
            ram(0, a, 1);
            check(st, 1);
            check(lat, lw + 1);
            @(posedge CLOCK);
        end
        $display("RAM access done");
        for (i = 0; i < 5; i++) begin
            ret = $random(seed);
            ko = $random(seed);
            apb(1, `SWPM_A_TMR_CMP, cmps[i]);
            apb(1, `SWPM_A_RETAIN, ret);
            apb(1, `SWPM_A_KEY_OUT, ko);
            apb(1, `SWPM_A_CTRL, ctls[i]);
            for (n = 0; n < 20 && SLEEPING !== 1'b1; n++) @(posedge CLOCK);
            check(OSC_EN, !ctls[i][1]);
            check(RAM_PWR_EN, ret);
            check(KEY_OUT, ko);
            check(GPIO_PWR, 0);
            k = $random(seed) & 3;
            if (i == 0) key_cmd <= key_cmd ^ (4'h1 << k);
            if (i == 1) irq_cmd <= 1'b1;
            for (n = 0; n < 3000 && CPU_RUN !== 1'b1; n++) @(posedge CLOCK);
            irq_cmd <= 1'b0;
            repeat (8) @(posedge CLOCK);
            check(CPU_RUN, 1);
            check(REF_ALT_SEL, ctls[i][4]);
            check(PLL_EN, ctls[i][4]);
            apb(0, `SWPM_A_WAKE_SRC, 0);
            check(rd[i == 0 ? k : i == 1 ? 4 : 5], 1);
            apb(1, `SWPM_A_WAKE_SRC, 32'h0000_003F);
            apb(0, `SWPM_A_WAKE_SRC, 0);
            check(rd, 0);
            apb(0, `SWPM_A_RETAIN, 0);
            check(rd, ret);
            $display("sleep case %0d done", i);
        end
        for (i = 0; i < 2; i++) begin
            apb(1, `SWPM_A_GATE, $random(seed) & 32'h0000_007F);
            apb(1, i ? `SWPM_A_SW_RST : `SWPM_A_CTRL, i ? `SWPM_RST_KEY : 32'h0000_0004);
            for (n = 0; n < 400 && SYS_RST_OUT !== 1'b1; n++) @(posedge CLOCK);
            check(SYS_RST_OUT, 1);
            for (n = 0; n < 400 && CPU_RUN === 1'b1; n++) @(posedge CLOCK);
            for (n = 0; n < 3000 && CPU_RUN !== 1'b1; n++) @(posedge CLOCK);
            apb(0, `SWPM_A_GATE, 0);
            check(rd, `SWPM_GATE_RST);
            apb(0, `SWPM_A_CTRL, 0);
            check(rd, `SWPM_CTRL_RST);
            $display("system reset case %0d done", i);
        end
        print_verdict;
    end
endmodule
`default_nettype wire
